//--- hdl/scr_register_map.sv
// Purpose: shared register map of a 16-channel serial controller
// Assumes: host port and firmware port on clock; fault pin async
// Notes:   one access per request, answer one cycle later

`include "scr_consts.svh"

module scr_register_map #(
  parameter logic [7:0]  BOARD_ID    = 8'h5a,   // arbitrary value
  parameter logic [15:0] OPTION_CODE = 16'h0001 // arbitrary value
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // host shared-memory port
  input  wire logic        host_req,
  input  wire logic        host_wr,
  input  wire logic [8:0]  host_addr,
  input  wire logic [1:0]  host_be,
  input  wire logic [15:0] host_wdata,
  output logic             host_ack,
  output logic [15:0]      host_rdata,
  // on-board firmware events
  input  wire logic [15:0] fw_tx_done,
  input  wire logic        fw_cst_we,
  input  wire logic [3:0]  fw_cst_chan,
  input  wire logic [15:0] fw_cst_set,
  input  wire logic        fw_st_done,
  input  wire logic        fw_st_fail,
  input  wire logic        fw_break_done,
  input  wire logic        fw_bus_error,
  input  wire logic        hw_fault_pin,
  input  wire logic [3:0]  fw_cfg_chan,
  // global controls
  output logic [15:0]      run_bits,
  output logic [15:0]      tx_request_bits,
  output logic [15:0]      rx_request_bits,
  output logic [15:0]      break_lines,
  output logic             indicator_off,
  output logic             board_reset_cmd,
  output logic             self_test_launch,
  output logic [5:0]       self_test_code,
  output logic             supervisor_only_slave,
  output logic             slave_wide_address,
  output logic             slave_decode_enable,
  output logic             master_mode,
  output logic [2:0]       master_bytes,
  output logic             busy_clear_irq,
  output logic             any_error_flag,
  // selected channel configuration
  output logic [1:0]       cfg_char_width,
  output logic [1:0]       cfg_parity_kind,
  output logic             cfg_parity_odd,
  output logic             cfg_two_stop,
  output logic             cfg_input_timeout,
  output logic             cfg_ring_buffer,
  output logic [1:0]       cfg_flow_control,
  output logic [7:0]       cfg_stop_code,
  output logic [7:0]       cfg_resume_code
);

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [1:0]  be);
    merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  logic [7:0]       self_test_flag_q, cmd_q, cmd1_q, cmd2_q, szam_q, stproc_q;
  logic [7:0]       ermsk_q, ervec_q, masgrn_q;
  logic [15:0]      go_q, tx_q, rx_q, brk_q, gst_q, bbase_h_q, bbase_l_q;
  logic [15:0]      cw_q [0:127];
  logic             soft_rst_q, hw_fault_m_q, hw_fault_s_q, busy_prev_q;
  logic [7:0]       apply_q;
  scr_pkg::scr_st_t st_q, st_d;
  logic [15:0]      rd_d, bemask;
  logic [8:0]       wa, coff;
  logic [6:0]       cidx;
  logic             rst, glob_hit, chan_hit, wen, reserved_nonzero_flag_hit, apply_done;
  logic             wr_id, wr_cmd, wr_go, wr_tx, wr_rx, wr_brk, wr_cmd2;
  logic             wr_szam, wr_ermsk, wr_bbh, wr_bbl, wr_gst, wr_mas;
  logic [7:0]       con1, con2;

  assign rst      = !reset_n || soft_rst_q;                     // [RL6]
  assign wa       = {host_addr[8:1], 1'b0};
  assign coff     = host_addr - `SCR_GREG_SIZE;
  assign cidx     = coff[7:1];
  assign glob_hit = host_addr < `SCR_GREG_SIZE;
  assign chan_hit = !glob_hit && host_addr < `SCR_MAP_END;
  assign wen      = host_req && host_wr;
  assign bemask   = {{8{host_be[1]}}, {8{host_be[0]}}};
  assign wr_id    = wen && glob_hit && wa == `SCR_OFS_ID;
  assign wr_cmd   = wen && glob_hit && wa == `SCR_OFS_CMD;
  assign wr_go    = wen && glob_hit && wa == `SCR_OFS_GO;
  assign wr_tx    = wen && glob_hit && wa == `SCR_OFS_TX;
  assign wr_rx    = wen && glob_hit && wa == `SCR_OFS_RX;
  assign wr_brk   = wen && glob_hit && wa == `SCR_OFS_BREAK;
  assign wr_cmd2  = wen && glob_hit && wa == `SCR_OFS_CMD2;
  assign wr_szam  = wen && glob_hit && wa == `SCR_OFS_SZAM;
  assign wr_ermsk = wen && glob_hit && wa == `SCR_OFS_ERMSK;
  assign wr_bbh   = wen && glob_hit && wa == `SCR_OFS_BBASE_H;
  assign wr_bbl   = wen && glob_hit && wa == `SCR_OFS_BBASE_L;
  assign wr_gst   = wen && glob_hit && wa == `SCR_OFS_GST;
  assign wr_mas   = wen && glob_hit && wa == `SCR_OFS_MASGRN;

  // reserved bytes, bad width codes and undefined test bits
  assign reserved_nonzero_flag_hit = wen && (                                    // [RL13]
      (chan_hit && cidx[2:0] == `SCR_CHW_RSV && |(host_wdata & bemask))
   || (glob_hit && wa >= `SCR_OFS_GRSV && |(host_wdata & bemask))
   || ((wr_cmd2 || wr_mas) && host_be[0] && |host_wdata[7:0])
   || (wr_szam && host_be[1] && host_wdata[15:14] == `SCR_SZ_BAD)
   || (wr_szam && host_be[0] && |(host_wdata[7:0] & `SCR_TEST_RSV)));

  // soft reset is one pulse; it clears itself, since the reset it raises does not clear it
  always_ff @(posedge clock) begin
    if (!reset_n)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= wr_cmd && host_be[1] && !soft_rst_q            // [RL6]
                    && host_wdata[8 + `SCR_CMD_RST];
  end

  // fault pin comes from outside the clock domain
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hw_fault_m_q <= 1'b0;
      hw_fault_s_q <= 1'b0;
    end else begin
      hw_fault_m_q <= hw_fault_pin;
      hw_fault_s_q <= hw_fault_m_q;
    end
  end

  // plain host-written configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      self_test_flag_q  <= `SCR_RESET_BYTE;
      cmd1_q    <= `SCR_RESET_BYTE;
      cmd2_q    <= `SCR_RESET_BYTE;
      szam_q    <= `SCR_RESET_BYTE;
      stproc_q  <= `SCR_RESET_BYTE;
      ermsk_q   <= `SCR_RESET_BYTE;
      ervec_q   <= `SCR_RESET_BYTE;
      masgrn_q  <= `SCR_RESET_BYTE;
      go_q      <= `SCR_RESET_WORD;
      rx_q      <= `SCR_RESET_WORD;
      brk_q     <= `SCR_RESET_WORD;
      bbase_h_q <= `SCR_RESET_WORD;
      bbase_l_q <= `SCR_RESET_WORD;
    end else begin
      if (wr_id && host_be[0]) self_test_flag_q <= host_wdata[7:0];
      if (wr_cmd && host_be[0]) cmd1_q <= host_wdata[7:0];
      if (wr_cmd2 && host_be[1]) cmd2_q <= host_wdata[15:8];
      if (wr_szam && host_be[1]) szam_q <= host_wdata[15:8];
      if (wr_szam && host_be[0]) stproc_q <= host_wdata[7:0];   // [RL24]
      if (wr_ermsk && host_be[1]) ermsk_q <= host_wdata[15:8];
      if (wr_ermsk && host_be[0]) ervec_q <= host_wdata[7:0];
      if (wr_mas && host_be[1]) masgrn_q <= host_wdata[15:8];
      if (wr_go) go_q <= merge(go_q, host_wdata, host_be);       // [RL1]
      if (wr_rx) rx_q <= merge(rx_q, host_wdata, host_be);       // [RL3]
      if (wr_brk) brk_q <= merge(brk_q, host_wdata, host_be);
      if (wr_bbh) bbase_h_q <= merge(bbase_h_q, host_wdata, host_be);
      if (wr_bbl) bbase_l_q <= merge(bbase_l_q, host_wdata, host_be);
    end
  end

  // command byte zero; test and break bits self-clear when done
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_q <= `SCR_RESET_BYTE;
    end else if (wr_cmd && host_be[1]) begin
      cmd_q <= host_wdata[15:8];
    end else begin
      if (st_q == scr_pkg::SCR_ST_FINISH)
        cmd_q[`SCR_CMD_TEST] <= 1'b0;                            // [RL7]
      if (fw_break_done)
        cmd_q[`SCR_CMD_BRK] <= 1'b0;                             // [RL8]
    end
  end

  // a host write in the clearing cycle wins over the completion
  always_ff @(posedge clock) begin
    if (rst)
      tx_q <= `SCR_RESET_WORD;
    else if (wr_tx)
      tx_q <= merge(tx_q & ~fw_tx_done, host_wdata, host_be);   // [RL2]
    else
      tx_q <= tx_q & ~fw_tx_done;                                 // [RL4]
  end

  // settle time the firmware takes to apply a register write
  always_ff @(posedge clock) begin
    if (rst)
      apply_q <= 8'h00;
    else if (wen && (glob_hit || chan_hit) && !wr_gst)
      apply_q <= 8'(`SCR_APPLY_CYC);
    else if (apply_q != 8'h00)
      apply_q <= apply_q - 8'h01;
  end
  assign apply_done = apply_q == 8'h01;

  // global status: hardware sets after the host write, so sets win
  always_ff @(posedge clock) begin
    logic [15:0] g;
    g = gst_q;
    if (apply_done)
      g[`SCR_GST_BUSY] = 1'b0;                                    // [RL15]
    if (wr_gst)
      g = merge(g, host_wdata, host_be);
    g[`SCR_GST_BERR] = g[`SCR_GST_BERR] | fw_bus_error;
    g[`SCR_GST_HWF]  = g[`SCR_GST_HWF] | hw_fault_s_q;          // [RL13]
    g[`SCR_GST_STF]  = g[`SCR_GST_STF] | (fw_st_done && fw_st_fail
                       && st_q == scr_pkg::SCR_ST_RUN);
    g[`SCR_GST_RESERVED_NONZERO_FLAG] = g[`SCR_GST_RESERVED_NONZERO_FLAG] | reserved_nonzero_flag_hit;
    if (rst)
      gst_q <= `SCR_RESET_WORD;
    else
      gst_q <= g & `SCR_GST_STORE;
  end

  // self-test sequencing
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      scr_pkg::SCR_ST_IDLE:
        if (cmd_q[`SCR_CMD_TEST]) st_d = scr_pkg::SCR_ST_RUN;     // [RL7]
      scr_pkg::SCR_ST_RUN:
        if (fw_st_done) st_d = scr_pkg::SCR_ST_FINISH;           // [RL17]
      scr_pkg::SCR_ST_FINISH:
        st_d = scr_pkg::SCR_ST_IDLE;
      default:
        st_d = scr_pkg::SCR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q             <= scr_pkg::SCR_ST_IDLE;
      self_test_launch <= 1'b0;
    end else begin
      st_q             <= st_d;
      self_test_launch <= st_d == scr_pkg::SCR_ST_RUN;           // [RL17]
    end
  end

  // channel register blocks; firmware status sets win over host clears
  always_ff @(posedge clock) begin
    logic [15:0] hw;
    hw = merge(cw_q[cidx], host_wdata, host_be);
    if (rst) begin
      for (int i = 0; i < 128; i++)
        cw_q[i] <= `SCR_RESET_WORD;
    end else begin
      if (wen && chan_hit)
        cw_q[cidx] <= hw;                                         // [RL22]
      if (fw_cst_we)                                              // [RL18]
        cw_q[{fw_cst_chan, `SCR_CHW_CST}] <= fw_cst_set |         // [RL19]
          ((wen && chan_hit && cidx == {fw_cst_chan, `SCR_CHW_CST})
           ? hw : cw_q[{fw_cst_chan, `SCR_CHW_CST}]);
    end
  end

  assign con1 = cw_q[{fw_cfg_chan, `SCR_CHW_CON1}][7:0];
  assign con2 = cw_q[{fw_cfg_chan, `SCR_CHW_CON2}][15:8];

  // decoded controls, all registered
  always_ff @(posedge clock) begin
    if (rst) begin
      break_lines       <= `SCR_RESET_WORD;
      master_bytes      <= `SCR_BYTES_32;
      any_error_flag    <= 1'b0;
      busy_prev_q       <= 1'b0;
      busy_clear_irq    <= 1'b0;
      self_test_code    <= 6'h00;
      cfg_char_width    <= 2'h0;
      cfg_parity_kind   <= 2'h0;
      cfg_parity_odd    <= 1'b0;
      cfg_two_stop      <= 1'b0;
      cfg_input_timeout <= 1'b0;
      cfg_ring_buffer   <= 1'b0;
      cfg_flow_control  <= 2'h0;
      cfg_stop_code     <= `SCR_RESET_BYTE;
      cfg_resume_code   <= `SCR_RESET_BYTE;
    end else begin
      break_lines    <= cmd_q[`SCR_CMD_BRK] ? brk_q : `SCR_RESET_WORD; // [RL8]
      case (szam_q[`SCR_SZ_WIDTH])                                // [RL23]
        `SCR_SZ_W32: master_bytes <= `SCR_BYTES_32;
        `SCR_SZ_W8:  master_bytes <= `SCR_BYTES_8;
        `SCR_SZ_W16: master_bytes <= `SCR_BYTES_16;
        default:     master_bytes <= `SCR_BYTES_BAD;
      endcase
      any_error_flag <= |(gst_q & `SCR_GST_ERRS);                 // [RL14]
      busy_prev_q    <= gst_q[`SCR_GST_BUSY];
      busy_clear_irq <= busy_prev_q && !gst_q[`SCR_GST_BUSY]      // [RL16]
                        && ermsk_q[`SCR_ERMSK_BUSY];
      self_test_code <= stproc_q[`SCR_TEST_BITS];                 // [RL24]
      cfg_char_width    <= con2[`SCR_FMT_CHAR];                   // [RL20]
      cfg_parity_kind   <= con2[`SCR_FMT_PKIND];
      cfg_parity_odd    <= con2[`SCR_FMT_PODD];
      cfg_two_stop      <= con2[`SCR_FMT_STOP2];
      cfg_input_timeout <= con2[`SCR_FMT_TMO];
      cfg_ring_buffer   <= con1[`SCR_CTL_RING];                   // [RL21]
      cfg_flow_control  <= con1[`SCR_CTL_FLOW];
      cfg_stop_code     <= cw_q[{fw_cfg_chan, `SCR_CHW_CHAN_STOP_FLOW_CODE}][7:0];  // [RL22]
      cfg_resume_code   <= cw_q[{fw_cfg_chan, `SCR_CHW_XON}][15:8];
    end
  end

  assign run_bits              = go_q;
  assign tx_request_bits       = tx_q;
  assign rx_request_bits       = rx_q;
  assign indicator_off         = cmd_q[`SCR_CMD_IND];             // [RL5]
  assign board_reset_cmd       = soft_rst_q;
  assign supervisor_only_slave = cmd_q[`SCR_CMD_SUP];             // [RL9]
  assign slave_wide_address    = cmd_q[`SCR_CMD_A32];             // [RL10]
  assign slave_decode_enable   = cmd_q[`SCR_CMD_DEC];             // [RL11]
  assign master_mode           = cmd_q[`SCR_CMD_MAST];            // [RL12]

  // read path; unmapped and global reserved words read zero, channel reserved words read back what was written
  always_comb begin
    rd_d = `SCR_RESET_WORD;
    if (chan_hit) begin
      rd_d = cw_q[cidx];
    end else if (glob_hit) begin
      case (wa)
        `SCR_OFS_ID:      rd_d = {BOARD_ID, self_test_flag_q};
        `SCR_OFS_OPTIONS: rd_d = OPTION_CODE;
        `SCR_OFS_CMD:     rd_d = {cmd_q, cmd1_q};
        `SCR_OFS_GO:      rd_d = go_q;
        `SCR_OFS_TX:      rd_d = tx_q;
        `SCR_OFS_RX:      rd_d = rx_q;
        `SCR_OFS_BREAK:   rd_d = brk_q;
        `SCR_OFS_CMD2:    rd_d = {cmd2_q, `SCR_RESET_BYTE};
        `SCR_OFS_SZAM:    rd_d = {szam_q, stproc_q};
        `SCR_OFS_ERMSK:   rd_d = {ermsk_q, ervec_q};
        `SCR_OFS_BBASE_H: rd_d = bbase_h_q;
        `SCR_OFS_BBASE_L: rd_d = bbase_l_q;
        `SCR_OFS_GST: begin
          rd_d = gst_q;
          rd_d[`SCR_GST_STB] = st_q == scr_pkg::SCR_ST_RUN;       // [RL17]
          rd_d[`SCR_GST_ANY] = |(gst_q & `SCR_GST_ERRS);          // [RL14]
        end
        `SCR_OFS_MASGRN:  rd_d = {masgrn_q, `SCR_RESET_BYTE};
        default:          rd_d = `SCR_RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      host_ack   <= 1'b0;
      host_rdata <= `SCR_RESET_WORD;
    end else begin
      host_ack   <= host_req;
      host_rdata <= (host_req && !host_wr) ? rd_d : `SCR_RESET_WORD;
    end
  end

  go_write_a: assert property (@(posedge clock) disable iff (rst) // [RL1]
    (wr_go && host_be == 2'b11) |=> run_bits == $past(host_wdata))
    else $error("run word not loaded from host write");

  tx_done_a: assert property (@(posedge clock) disable iff (rst) // [RL4]
    (!wr_tx && fw_tx_done != 16'h0000)
      |=> (tx_request_bits & $past(fw_tx_done)) == 16'h0000)
    else $error("finished transmit left request bit set");

  ind_write_a: assert property (@(posedge clock) disable iff (rst) // [RL5]
    (wr_cmd && host_be[1])
      |=> indicator_off == $past(host_wdata[8 + `SCR_CMD_IND]))
    else $error("indicator does not follow command bit");

  board_reset_a: assert property (@(posedge clock) disable iff (!reset_n) // [RL6]
    (wr_cmd && host_be[1] && host_wdata[8 + `SCR_CMD_RST] && !soft_rst_q)
      |=> board_reset_cmd ##1 (!board_reset_cmd && run_bits == 16'h0000))
    else $error("board reset did not pulse and clear");

  test_launch_a: assert property (@(posedge clock) disable iff (rst) // [RL7]
    (st_q == scr_pkg::SCR_ST_IDLE && cmd_q[`SCR_CMD_TEST])
      |=> self_test_launch)
    else $error("self-test not launched");

  break_out_a: assert property (@(posedge clock) disable iff (rst) // [RL8]
    ##1 break_lines == ($past(cmd_q[`SCR_CMD_BRK]) ? $past(brk_q) : 16'h0000))
    else $error("break lines wrong");

  any_error_a: assert property (@(posedge clock) disable iff (rst) // [RL14]
    ##1 any_error_flag == |($past(gst_q) & `SCR_GST_ERRS))
    else $error("any-error flag differs from error bits");

  busy_irq_a: assert property (@(posedge clock) disable iff (rst) // [RL16]
    ($fell(gst_q[`SCR_GST_BUSY]) && ermsk_q[`SCR_ERMSK_BUSY])
      |=> busy_clear_irq)
    else $error("busy clear interrupt missing");

  test_end_a: assert property (@(posedge clock) disable iff (rst) // [RL17]
    (st_q == scr_pkg::SCR_ST_RUN && fw_st_done)
      |=> !self_test_launch ##1 (!self_test_launch && !cmd_q[`SCR_CMD_TEST]))
    else $error("self-test running flag did not end");

  width_dec_a: assert property (@(posedge clock) disable iff (rst) // [RL23]
    (szam_q[`SCR_SZ_WIDTH] == `SCR_SZ_W16 && $stable(szam_q))
      |=> master_bytes == `SCR_BYTES_16)
    else $error("master width decode wrong");

endmodule

//--- hdl/scr_consts.svh
// Purpose: constants of the serial controller register map
// Assumes: 16-bit shared words, even byte address = upper byte
// Notes:   offsets are byte addresses into the shared window
//
// Functional notes
// RL1 - channel run word: bit n runs channel n
// RL2 - transmit request word: bit n per channel
// RL3 - receive request word: bit n per channel
// RL4 - finished transmission clears its request bit
// RL5 - command bit 01 one turns indicator off
// RL6 - command bit 02 one resets whole board
// RL7 - command bit 04 launches selected self-test
// RL8 - command bit 08 sends break on marked channels
// RL9 - command bit 10 limits slave to supervisor
// RL10 - command bit 20 selects 32-bit slave decode
// RL11 - command bit 40 enables slave address decoder
// RL12 - command bit 80 selects master, buffers off-board
// RL13 - status flags hardware, self-test, reserved-field errors
// RL14 - status bit 8000 is OR of errors
// RL15 - status bit 0080 busy until device clears
// RL16 - busy falling raises interrupt when enabled
// RL17 - status bit 2000 set while self-test runs
// RL18 - channel status receive and transmitter flags
// RL19 - channel status user buffer, illegal parameter
// RL20 - format byte defines character frame fields
// RL21 - control byte: ring select, flow control
// RL22 - per-channel stop and resume flow codes
// RL23 - master width: 00 32, 01 8, 10 16
// RL24 - self-test select: one test per bit
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

`define SCR_RESET_WORD  16'h0000
`define SCR_RESET_BYTE  8'h00
`define SCR_GREG_SIZE   9'h020
`define SCR_MAP_END     9'h120

// global byte offsets (word aligned)
`define SCR_OFS_ID      9'h000
`define SCR_OFS_OPTIONS 9'h002
`define SCR_OFS_CMD     9'h004
`define SCR_OFS_GO      9'h006
`define SCR_OFS_TX      9'h008
`define SCR_OFS_RX      9'h00a
`define SCR_OFS_BREAK   9'h00c
`define SCR_OFS_CMD2    9'h00e
`define SCR_OFS_SZAM    9'h010
`define SCR_OFS_ERMSK   9'h012
`define SCR_OFS_BBASE_H 9'h014
`define SCR_OFS_BBASE_L 9'h016
`define SCR_OFS_GST     9'h018
`define SCR_OFS_MASGRN  9'h01a
`define SCR_OFS_GRSV    9'h01c

// command byte zero bit positions
`define SCR_CMD_IND     0
`define SCR_CMD_RST     1
`define SCR_CMD_TEST    2
`define SCR_CMD_BRK     3
`define SCR_CMD_SUP     4
`define SCR_CMD_A32     5
`define SCR_CMD_DEC     6
`define SCR_CMD_MAST    7

// global status bit positions
`define SCR_GST_BUSY    7
`define SCR_GST_BERR    8
`define SCR_GST_HWF     9
`define SCR_GST_STF     10
`define SCR_GST_RESERVED_NONZERO_FLAG    11
`define SCR_GST_STB     13
`define SCR_GST_ANY     15
`define SCR_GST_STORE   16'h0f80
`define SCR_GST_ERRS    16'h0f00
`define SCR_ERMSK_BUSY  7

// channel word indices (byte offset / 2)
`define SCR_CHW_CST     3'd0
`define SCR_CHW_CHAN_STOP_FLOW_CODE    3'd2
`define SCR_CHW_XON     3'd3
`define SCR_CHW_CON1    3'd5
`define SCR_CHW_CON2    3'd6
`define SCR_CHW_RSV     3'd7

// channel field ranges
`define SCR_FMT_CHAR    1:0
`define SCR_FMT_PODD    2
`define SCR_FMT_PKIND   4:3
`define SCR_FMT_STOP2   5
`define SCR_FMT_TMO     7
`define SCR_CTL_FLOW    6:5
`define SCR_CTL_RING    7

// master size and self-test select
`define SCR_SZ_WIDTH    7:6
`define SCR_SZ_W32      2'b00
`define SCR_SZ_W8       2'b01
`define SCR_SZ_W16      2'b10
`define SCR_SZ_BAD      2'b11
`define SCR_BYTES_32    3'd4
`define SCR_BYTES_8     3'd1
`define SCR_BYTES_16    3'd2
`define SCR_BYTES_BAD   3'd0
`define SCR_TEST_BITS   5:0
`define SCR_TEST_RSV    8'hc0

// register apply time
`define SCR_CLK_MHZ     50
`define SCR_APPLY_NS    200
`define SCR_APPLY_CYC   ((`SCR_APPLY_NS * `SCR_CLK_MHZ + 999) / 1000)

`endif

//--- hdl/scr_pkg.sv
// Purpose: types of the serial controller register map
// Assumes: nothing
// Notes:   self-test sequencing states, gray except the finish-to-idle step
package scr_pkg;

  typedef enum logic [1:0] {
    SCR_ST_IDLE   = 2'b00,
    SCR_ST_RUN    = 2'b01,
    SCR_ST_FINISH = 2'b11
  } scr_st_t;

endpackage

//--- sim/scr_host_model.sv
// Purpose: host cpu model on the shared-memory port
// Assumes: request pulses one cycle, answer exactly one cycle later
// Notes:   released address and data lines show the inverse of their last value
module scr_host_model (
  // clock
  input  wire logic        clock,
  // answer
  input  wire logic        host_ack,
  input  wire logic [15:0] host_rdata,
  // request
  output logic             host_req,
  output logic             host_wr,
  output logic [8:0]       host_addr,
  output logic [1:0]       host_be,
  output logic [15:0]      host_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        ack_ok;
  logic [15:0] last_q;
  initial begin
    host_req = 0;
    host_wr = 0;
    host_addr = 0;
    host_be = 0;
    host_wdata = 0;
  end
  task automatic acc(input logic w, input logic [8:0] a,
                     input logic [1:0] be, input logic [15:0] d);
    @(posedge clock);
    host_req <= 1;
    host_wr <= w;
    host_addr <= a;
    host_be <= be;
    host_wdata <= d;
    @(posedge clock);
    host_req <= 0;
    host_addr <= ~a;
    host_wdata <= ~d;
    @(posedge clock);
    ack_ok = host_ack;
    last_q = host_rdata;
  endtask
endmodule

//--- sim/scr_register_map_tb.sv
// Purpose: self-checking bench of the serial register map
// Assumes: host model issues one access at a time
// Notes:   fixed 10-cycle apply time is waited out, not polled
`include "scr_consts.svh"
module scr_register_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset_n, host_req, host_wr, host_ack;
  logic [8:0] host_addr;
  logic [1:0] host_be;
  logic [15:0] host_wdata, host_rdata, fw_tx_done, fw_cst_set;
  logic fw_cst_we, fw_st_done, fw_st_fail, fw_break_done, fw_bus_error;
  logic hw_fault_pin, indicator_off, board_reset_cmd, self_test_launch;
  logic [3:0] fw_cst_chan, fw_cfg_chan;
  logic [15:0] run_bits, tx_request_bits, rx_request_bits, break_lines;
  logic [5:0] self_test_code;
  logic supervisor_only_slave, slave_wide_address, slave_decode_enable;
  logic master_mode, busy_clear_irq, any_error_flag;
  logic [2:0] master_bytes;
  logic [1:0] cfg_char_width, cfg_parity_kind, cfg_flow_control;
  logic cfg_parity_odd, cfg_two_stop, cfg_input_timeout, cfg_ring_buffer;
  logic [7:0] cfg_stop_code, cfg_resume_code;
  int num_errors = 0, comparisons = 0;
  bit irq_seen, rst_seen;
  logic [7:0] cmd_tab [3] = '{8'hf1, 8'h50, 8'h00};
  logic [2:0] size_tab [3] = '{3'd4, 3'd1, 3'd2};
  logic [7:0] v;

  scr_register_map dut (.*);
  scr_host_model host (.*);

  always #10 clock = ~clock;
  // pulses are too short to poll from the access tasks
  always @(posedge clock) begin
    if (busy_clear_irq) irq_seen <= 1;
    if (board_reset_cmd) rst_seen <= 1;
  end

  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    host.acc(1'b1, a, be, d);
  endtask
  task automatic rd_chk(input string n, input logic [8:0] a,
                        input logic [15:0] e);
    host.acc(1'b0, a, 2'b11, 16'h0000);
    chk("ack", 16'h0001, 16'(host.ack_ok));
    chk(n, e, host.last_q);
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clock);
    num_errors++;
    finish_test();
  end

  initial begin
    reset_n = 0;
    fw_tx_done = 0;
    fw_cst_we = 0;
    fw_cst_chan = 3;
    fw_cst_set = 16'h073f;
    fw_st_done = 0;
    fw_st_fail = 0;
    fw_break_done = 0;
    fw_bus_error = 0;
    hw_fault_pin = 0;
    fw_cfg_chan = 5;
    repeat (8) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    chk("bytes", 16'h0004, 16'(master_bytes));
    wr(`SCR_OFS_GO, 2'b11, 16'h8001);
    wr(`SCR_OFS_TX, 2'b11, 16'h0006);
    wr(`SCR_OFS_RX, 2'b11, 16'h4002);
    chk("run", 16'h8001, run_bits);
    chk("rxbits", 16'h4002, rx_request_bits);
    rd_chk("rx", `SCR_OFS_RX, 16'h4002);
    fw_tx_done <= 16'h0004;
    @(posedge clock) fw_tx_done <= 16'h0000;
    @(posedge clock);
    chk("tx", 16'h0002, tx_request_bits);
    $display("done request words");
    for (int i = 0; i < 3; i++) begin
      v = cmd_tab[i];
      wr(`SCR_OFS_CMD, 2'b10, {v, 8'h00});
      chk("cmd", 16'({v[7], v[6], v[5], v[4], v[0]}),
          16'({master_mode, slave_decode_enable, slave_wide_address,
               supervisor_only_slave, indicator_off}));
      wr(`SCR_OFS_SZAM, 2'b10, {2'(i), 14'h0000});
      @(posedge clock);
      chk("size", 16'(size_tab[i]), 16'(master_bytes));
    end
    $display("done command and size");
    wr(`SCR_OFS_SZAM, 2'b01, 16'h0004);
    wr(`SCR_OFS_CMD, 2'b10, 16'h0400);
    repeat (2) @(posedge clock);
    chk("test", 16'h0044, {9'h000, self_test_launch, self_test_code});
    rd_chk("gst", `SCR_OFS_GST, 16'h2000);
    fw_st_done <= 1;
    fw_st_fail <= 1;
    @(posedge clock) fw_st_done <= 0;
    fw_st_fail <= 0;
    repeat (2) @(posedge clock);
    rd_chk("gst", `SCR_OFS_GST, 16'h8400);
    chk("any_error_flag", 16'h0001, 16'(any_error_flag));
    wr(`SCR_OFS_GST, 2'b11, 16'h0000);
    wr(`SCR_OFS_BREAK, 2'b11, 16'h0081);
    wr(`SCR_OFS_CMD, 2'b10, 16'h0800);
    @(posedge clock);
    chk("break", 16'h0081, break_lines);
    wr(`SCR_OFS_SZAM, 2'b10, 16'hc000);
    @(posedge clock);
    chk("bad size", 16'h0000, 16'(master_bytes));
    wr(`SCR_OFS_GRSV, 2'b11, 16'h0001);
    hw_fault_pin <= 1;
    repeat (4) @(posedge clock);
    rd_chk("gst", `SCR_OFS_GST, 16'h8a00);
    hw_fault_pin <= 0;
    repeat (4) @(posedge clock);
    wr(`SCR_OFS_GST, 2'b11, 16'h0000);
    rd_chk("gst", `SCR_OFS_GST, 16'h0000);
    $display("done self-test and errors");
    fw_cst_we <= 1;
    @(posedge clock) fw_cst_we <= 0;
    rd_chk("cst", 9'h050, 16'h073f);
    wr(9'h074, 2'b01, 16'h0013);
    wr(9'h076, 2'b10, 16'h1100);
    wr(9'h07a, 2'b01, 16'h00a0);
    wr(9'h07c, 2'b10, 16'hbe00);
    @(posedge clock);
    chk("codes", 16'h1311, {cfg_stop_code, cfg_resume_code});
    chk("ctl", 16'h0005, 16'({cfg_ring_buffer, cfg_flow_control}));
    chk("fmt", 16'h007e, 16'({cfg_input_timeout, cfg_two_stop,
        cfg_parity_kind, cfg_parity_odd, cfg_char_width}));
    $display("done channel");
    wr(`SCR_OFS_ERMSK, 2'b10, 16'h8000);
    wr(`SCR_OFS_GST, 2'b01, 16'h0080);
    wr(`SCR_OFS_GO, 2'b11, 16'h0003);
    rd_chk("busy", `SCR_OFS_GST, 16'h0080);
    repeat (12) @(posedge clock);
    rd_chk("idle", `SCR_OFS_GST, 16'h0000);
    chk("irq", 16'h0001, 16'(irq_seen));
    wr(`SCR_OFS_CMD, 2'b10, 16'h0200);
    repeat (2) @(posedge clock);
    chk("reset", 16'h0001, 16'(rst_seen));
    chk("run", 16'h0000, run_bits);
    $display("done busy and board reset");
    finish_test();
  end
endmodule
